// ### design/irs_sequencer.sv
// Internal reset sequencer: watchdog and low-voltage resets with recovery
`timescale 1ns/100ps
`default_nettype none

module irs_sequencer
   import irs_pkg::*;
#(
   parameter int STAB_CYCLES    = IRS_STAB_CYCLES,
   parameter int WDT_RST_CYCLES = IRS_WDT_RST_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   // Register port
   input  wire logic [3:0]           addr_in,
   input  wire logic [31:0]          wdata_in,
   input  wire logic                 wr_in,
   input  wire logic                 rd_in,
   output logic      [31:0]          rdata_out,
   // Event sources
   input  wire logic                 watchdog_overflow_reset_in,
   input  wire logic                 lowvolt_detect_in,
   // Clock control
   output irs_clk_ctl_t              clk_ctl_out,
   output logic [IRS_DIV_W-1:0]      cpu_div_out,
   output logic [IRS_PRESC_W:0]      periph_tick_out,
   output logic                      cpu_clock_status_out,
   // Resets and run controls
   output logic                      cpu_rst_n_out,
   output logic                      periph_rst_n_out,
   output logic                      wdt_clear_out,
   output logic                      wdt_run_out,
   output logic                      ram_wr_block_out,
   output logic                      lowvolt_irq_out,
   output logic [7:0]                debug_mode_reg_out
);

   localparam logic [IRS_CNT_W-1:0] STAB_LAST = IRS_CNT_W'(STAB_CYCLES - 1);
   localparam logic [IRS_CNT_W-1:0] WRST_LAST = IRS_CNT_W'(WDT_RST_CYCLES - 1);

   irs_state_t                 state_r;
   irs_state_t                 state_nxt;
   logic [IRS_CNT_W-1:0]       cnt_r;
   logic [IRS_PRESC_W-1:0]     presc_r;
   logic                       lvd_meta_r;
   logic                       lvd_sync_r;
   logic                       lvd_prev_r;
   logic                       wdt_mode_r;
   logic                       lvi_en_r;
   logic                       lowvolt_reset_select_r;
   logic [IRS_DIV_W-1:0]       div_r;
   logic                       int_clk_r;
   logic                       wdog_reset_flag_r;
   logic                       lowvolt_reset_flag_r;
   logic [7:0]                 debug_mode_reg_r;
   logic                       in_reset;
   logic                       wdt_req;
   logic                       lvi_req;
   logic                       emergency;
   logic                       wr_ctrl;
   logic                       wr_flags;
   logic                       wr_debug;

   function automatic logic hit(input logic wr, input logic [3:0] a, input logic [3:0] ofs);
      hit = wr && (a == ofs);
   endfunction

   // Detector output is asynchronous to this clock
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lvd_meta_r <= 1'b0;
         lvd_sync_r <= 1'b0;
         lvd_prev_r <= 1'b0;
      end else begin
         lvd_meta_r <= lowvolt_detect_in;
         lvd_sync_r <= lvd_meta_r;
         lvd_prev_r <= lvd_sync_r;
      end
   end

   assign in_reset  = (state_r == IRS_ST_WRST) || (state_r == IRS_ST_LRST);
   assign wdt_req   = watchdog_overflow_reset_in && wdt_mode_r && !in_reset;
   assign lvi_req   = lvd_sync_r && lvi_en_r && lowvolt_reset_select_r;
   assign emergency = (state_r == IRS_ST_STAB) && watchdog_overflow_reset_in;
   assign wr_ctrl   = hit(wr_in, addr_in, IRS_CTRL_OFS);
   assign wr_flags  = hit(wr_in, addr_in, IRS_FLAGS_OFS);
   assign wr_debug  = hit(wr_in, addr_in, IRS_DEBUG_OFS);

   // Sequencer next state; low voltage outranks the watchdog
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         IRS_ST_WRST: begin
            if (lvi_req) begin
               state_nxt = IRS_ST_LRST;
            end else if (cnt_r == WRST_LAST) begin
               state_nxt = IRS_ST_STAB;
            end
         end
         IRS_ST_LRST: begin
            if (!lvi_req) begin
               state_nxt = IRS_ST_STAB;
            end
         end
         IRS_ST_STAB: begin
            if (lvi_req) begin
               state_nxt = IRS_ST_LRST;
            end else if (emergency) begin
               state_nxt = IRS_ST_RUN;
            end else if (cnt_r == STAB_LAST) begin
               state_nxt = IRS_ST_RUN;
            end
         end
         IRS_ST_RUN: begin
            if (lvi_req) begin
               state_nxt = IRS_ST_LRST;
            end else if (wdt_req) begin
               state_nxt = IRS_ST_WRST;
            end
         end
         default: begin
            state_nxt = IRS_ST_STAB;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= IRS_ST_STAB;
      end else begin
         state_r <= state_nxt;
      end
   end

   // One counter serves reset length and stabilization; restarts on every state change
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_r <= '0;
      end else if (state_nxt != state_r) begin
         cnt_r <= '0;
      end else if (state_r == IRS_ST_WRST || state_r == IRS_ST_STAB) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Clock source: internal oscillator only after an emergency start
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         int_clk_r <= 1'b0;
      end else if (in_reset) begin
         int_clk_r <= 1'b0;
      end else if (emergency && !lvi_req) begin
         int_clk_r <= 1'b1;
      end
   end

   // Peripheral prescaler frozen and cleared until the clocks are released
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         presc_r <= '0;
      end else if (state_r != IRS_ST_RUN) begin
         presc_r <= '0;
      end else begin
         presc_r <= presc_r + 1'b1;
      end
   end

   // Running AND of the low bits; a loop-indexed slice would not elaborate
   always_comb begin
      logic ones;
      ones = 1'b1;
      periph_tick_out[0] = (state_r == IRS_ST_RUN);
      for (int i = 1; i <= IRS_PRESC_W; i++) begin
         ones               = ones && presc_r[i-1];
         periph_tick_out[i] = (state_r == IRS_ST_RUN) && ones;
      end
   end

   // Control register mode bits; only an external reset restores them, so the low-voltage
   // settings survive the reset they themselves cause
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         {lowvolt_reset_select_r, lvi_en_r, wdt_mode_r} <= IRS_CTRL_INIT;
      end else if (wr_ctrl) begin
         wdt_mode_r             <= wdata_in[IRS_CTRL_WDT_MODE_BIT];
         lvi_en_r               <= wdata_in[IRS_CTRL_LVI_EN_BIT];
         lowvolt_reset_select_r <= wdata_in[IRS_CTRL_LVI_SEL_BIT];
      end
   end

   // CPU divider returns to one-eighth on any reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || in_reset) begin
         div_r <= IRS_DIV_INIT;
      end else if (wr_ctrl) begin
         div_r <= wdata_in[IRS_CTRL_DIV_LSB +: IRS_DIV_W];
      end
   end

   // Reset-source flags: zero writes clear, a new reset wins
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wdog_reset_flag_r    <= 1'b0;
         lowvolt_reset_flag_r <= 1'b0;
      end else begin
         if (state_nxt == IRS_ST_WRST && state_r != IRS_ST_WRST) begin
            wdog_reset_flag_r <= 1'b1;
         end else if (wr_flags && !wdata_in[IRS_FLAG_WDT_BIT]) begin
            wdog_reset_flag_r <= 1'b0;
         end
         if (state_nxt == IRS_ST_LRST && state_r != IRS_ST_LRST) begin
            lowvolt_reset_flag_r <= 1'b1;
         end else if (wr_flags && !wdata_in[IRS_FLAG_LVI_BIT]) begin
            lowvolt_reset_flag_r <= 1'b0;
         end
      end
   end

   // Debug mode register ignores internal resets
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         debug_mode_reg_r <= IRS_DEBUG_INIT;
      end else if (wr_debug && !in_reset) begin
         debug_mode_reg_r <= wdata_in[7:0];
      end
   end

   // Interrupt on detect edge when reset is not selected
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lowvolt_irq_out <= 1'b0;
      end else begin
         lowvolt_irq_out <= lvd_sync_r && !lvd_prev_r && lvi_en_r
                            && !lowvolt_reset_select_r && !in_reset;
      end
   end

   // Registered outputs; release edges come from flip-flops only
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         clk_ctl_out          <= '0;
         cpu_rst_n_out        <= 1'b0;
         periph_rst_n_out     <= 1'b0;
         wdt_clear_out        <= 1'b1;
         wdt_run_out          <= 1'b0;
         ram_wr_block_out     <= 1'b1;
         cpu_clock_status_out <= 1'b0;
      end else begin
         clk_ctl_out.main_osc <= !in_reset;
         clk_ctl_out.int_osc  <= !in_reset;
         clk_ctl_out.periph   <= (state_r == IRS_ST_RUN);
         clk_ctl_out.sys      <= (state_r == IRS_ST_RUN);
         cpu_rst_n_out        <= (state_r == IRS_ST_RUN);
         periph_rst_n_out     <= !in_reset;
         wdt_clear_out        <= in_reset;
         wdt_run_out          <= !in_reset;
         ram_wr_block_out     <= in_reset;
         cpu_clock_status_out <= int_clk_r;
      end
   end

   assign cpu_div_out        = div_r;
   assign debug_mode_reg_out = debug_mode_reg_r;

   // Read data present only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !rd_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= '0;
         case (addr_in)
            IRS_CTRL_OFS: begin
               rdata_out[IRS_CTRL_WDT_MODE_BIT]            <= wdt_mode_r;
               rdata_out[IRS_CTRL_LVI_EN_BIT]              <= lvi_en_r;
               rdata_out[IRS_CTRL_LVI_SEL_BIT]             <= lowvolt_reset_select_r;
               rdata_out[IRS_CTRL_DIV_LSB +: IRS_DIV_W]    <= div_r;
            end
            IRS_STATUS_OFS: begin
               rdata_out[IRS_STAT_CLK_BIT]                 <= int_clk_r;
               rdata_out[IRS_STAT_STATE_LSB +: 3]          <= state_r;
            end
            IRS_FLAGS_OFS: begin
               rdata_out[IRS_FLAG_WDT_BIT]                 <= wdog_reset_flag_r;
               rdata_out[IRS_FLAG_LVI_BIT]                 <= lowvolt_reset_flag_r;
            end
            IRS_DEBUG_OFS: begin
               rdata_out[7:0]                              <= debug_mode_reg_r;
            end
            default: begin
               rdata_out <= '0;
            end
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   wdt_reset_entry_a: assert property (
      (state_r == IRS_ST_RUN) && wdt_req && !lvi_req |=> state_r == IRS_ST_WRST)
      else $error("watchdog overflow did not enter reset");

   wdt_reset_len_a: assert property (
      (state_r == IRS_ST_WRST) && !lvi_req && (cnt_r != WRST_LAST)
      |=> state_r == IRS_ST_WRST)
      else $error("watchdog reset ended too soon");

   main_osc_stop_a: assert property (
      in_reset |=> !clk_ctl_out.main_osc && !clk_ctl_out.int_osc)
      else $error("oscillator ran during reset");

   periph_clk_gate_a: assert property (
      periph_tick_out != '0 |-> state_r == IRS_ST_RUN)
      else $error("peripheral tick outside run");

   div_init_a: assert property (
      in_reset |=> cpu_div_out == IRS_DIV_INIT)
      else $error("cpu divider not reinitialized");

   cpu_hold_a: assert property (
      state_r != IRS_ST_RUN |=> !cpu_rst_n_out)
      else $error("cpu released early");

   lvi_hold_a: assert property (
      (state_r == IRS_ST_LRST) && lvi_req |=> state_r == IRS_ST_LRST)
      else $error("low-voltage reset dropped with detect active");

   lvi_irq_a: assert property (
      lowvolt_irq_out |-> !$past(lowvolt_reset_select_r) && $past(lvi_en_r) && !$past(in_reset))
      else $error("interrupt raised in reset mode");

   emerg_start_a: assert property (
      emergency && !lvi_req |=> state_r == IRS_ST_RUN ##1 cpu_clock_status_out)
      else $error("emergency start not taken");

   flag_set_wins_a: assert property (
      state_nxt == IRS_ST_WRST && state_r != IRS_ST_WRST |=> wdog_reset_flag_r)
      else $error("watchdog flag lost");

   wdt_run_a: assert property (
      $fell(in_reset) |=> wdt_run_out && !wdt_clear_out)
      else $error("watchdog not started at release");

endmodule

`default_nettype wire

// ### inc/irs_pkg.sv
// Shared constants and types of the internal reset sequencer
package irs_pkg;

   // Register offsets (byte addresses, one word each)
   localparam logic [3:0] IRS_CTRL_OFS   = 4'h0;
   localparam logic [3:0] IRS_STATUS_OFS = 4'h4;
   localparam logic [3:0] IRS_FLAGS_OFS  = 4'h8;
   localparam logic [3:0] IRS_DEBUG_OFS  = 4'hc;

   // Control register fields
   localparam int IRS_CTRL_WDT_MODE_BIT = 0;
   localparam int IRS_CTRL_LVI_EN_BIT   = 1;
   localparam int IRS_CTRL_LVI_SEL_BIT  = 2;
   localparam int IRS_CTRL_DIV_LSB      = 4;
   localparam int IRS_DIV_W             = 3;

   // Status register fields
   localparam int IRS_STAT_CLK_BIT   = 0;
   localparam int IRS_STAT_STATE_LSB = 4;

   // Reset-source flag positions
   localparam int IRS_FLAG_LVI_BIT = 0;
   localparam int IRS_FLAG_WDT_BIT = 4;

   // Reset values
   localparam logic [IRS_DIV_W-1:0] IRS_DIV_INIT   = 3'h3;
   localparam logic [7:0]           IRS_DEBUG_INIT = 8'h01;
   localparam logic [2:0]           IRS_CTRL_INIT  = 3'h0;

   // Cycle counts (stabilization in main-clock periods)
   localparam int IRS_STAB_EXP        = 16;
   localparam int IRS_STAB_CYCLES     = 2 ** IRS_STAB_EXP;
   localparam int IRS_WDT_RST_CYCLES  = 64;
   localparam int IRS_CNT_W           = 17;
   localparam int IRS_PRESC_W         = 10;

   typedef enum logic [2:0] {
      IRS_ST_WRST = 3'b000,
      IRS_ST_LRST = 3'b001,
      IRS_ST_STAB = 3'b010,
      IRS_ST_RUN  = 3'b011
   } irs_state_t;

   typedef struct packed {
      logic main_osc;
      logic int_osc;
      logic periph;
      logic sys;
   } irs_clk_ctl_t;

endpackage

// ### tb/irs_far_model.sv
// Far-side model: watchdog counter with overflow pulse, low-voltage detector
`timescale 1ns/100ps
`default_nettype none

module irs_far_model #(
   parameter int OVF_LIMIT = 8
) (
   // Clock
   input  wire logic clk_in,
   // From the sequencer
   input  wire logic wdt_clear_in,
   input  wire logic wdt_run_in,
   // Bench commands
   input  wire logic kick_in,
   input  wire logic auto_en_in,
   input  wire logic low_supply_in,
   // To the sequencer
   output logic      overflow_out,
   output logic      lowvolt_detect_out
);
   logic [15:0] count_r;

   always_ff @(posedge clk_in) begin
      if (wdt_clear_in) begin
         count_r <= 16'h0;
      end else if (wdt_run_in) begin
         count_r <= count_r + 16'h1;
      end
   end

   // Automatic overflow only from a running counter, so a main clock that never settles still ends STAB
   always_ff @(posedge clk_in) begin
      overflow_out <= kick_in | (auto_en_in & wdt_run_in & (count_r == 16'(OVF_LIMIT)));
   end

   assign lowvolt_detect_out = low_supply_in;
endmodule

`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench of the internal reset sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import irs_pkg::*;
   localparam int STAB = 32;
   localparam int WRST = 4;
   logic         clk_in   = 1'b0;
   logic         rst_n_in = 1'b0;
   logic [3:0]   addr     = 4'h0;
   logic [31:0]  wdata    = 32'h0;
   logic         wr       = 1'b0;
   logic         rd       = 1'b0;
   logic         kick     = 1'b0;
   logic         auto_en  = 1'b0;
   logic         low_sup  = 1'b0;
   logic         rd_seen  = 1'b0;
   logic [31:0]  seed     = 32'h18cefe19;
   logic [31:0]  rdata;
   irs_clk_ctl_t clk_ctl;
   logic [2:0]   div;
   logic [7:0]   dbg;
   logic [10:0]  tick;
   logic         ovf, lv_det, clk_st, cpu_rst_n, per_rst_n, wclr, wrun, ram_blk, irq;
   logic [31:0]  exp_q[$];
   int           n_fail   = 0;
   int           compares = 0;
   int           n;
   logic [2:0]   div_sel  = 3'h5;
   logic [7:0]   dbg_val  = 8'h0;

   always #20 clk_in = ~clk_in;

   irs_sequencer #(.STAB_CYCLES(STAB), .WDT_RST_CYCLES(WRST)) dut_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .watchdog_overflow_reset_in(ovf),
      .lowvolt_detect_in(lv_det), .clk_ctl_out(clk_ctl), .cpu_div_out(div),
      .periph_tick_out(tick), .cpu_clock_status_out(clk_st), .cpu_rst_n_out(cpu_rst_n),
      .periph_rst_n_out(per_rst_n), .wdt_clear_out(wclr), .wdt_run_out(wrun),
      .ram_wr_block_out(ram_blk), .lowvolt_irq_out(irq), .debug_mode_reg_out(dbg));

   irs_far_model #(.OVF_LIMIT(8)) far_u (
      .clk_in(clk_in), .wdt_clear_in(wclr), .wdt_run_in(wrun), .kick_in(kick),
      .auto_en_in(auto_en), .low_supply_in(low_sup), .overflow_out(ovf),
      .lowvolt_detect_out(lv_det));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch reg t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch pin t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      rd   <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe; looked at mid-cycle
   always @(posedge clk_in) begin
      rd_seen <= rd;
   end

   always @(negedge clk_in) begin
      if (rd_seen && exp_q.size() > 0) begin
         chk_reg(rdata, exp_q.pop_front());
      end
   end

   task automatic wait_cpu(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (cpu_rst_n !== lvl && cnt < lim) begin
         @(negedge clk_in);
         cnt++;
      end
      chk_pin(32'(cpu_rst_n), 32'(lvl));
   endtask

   task automatic kick_once();
      @(posedge clk_in);
      kick <= 1'b1;
      @(posedge clk_in);
      kick <= 1'b0;
   endtask

   task automatic test_done();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk_in);
      n_fail++;
      test_done();
   end

   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      chk_pin(32'(clk_ctl), 32'hc);
      chk_pin(32'({wrun, wclr, cpu_rst_n, tick[0]}), 32'h8);
      wait_cpu(1'b1, 400, n);
      chk_pin(32'(n >= STAB - 1 && n <= STAB + 3), 32'h1);
      chk_pin(32'(clk_ctl), 32'hf);
      chk_pin(32'({div, tick[0], clk_st, ram_blk}), 32'h1c);
      reg_rd(IRS_STATUS_OFS, 32'h30);
      reg_rd(IRS_FLAGS_OFS, 32'h0);
      seed = lfsr(seed);
      reg_wr(4'h2, seed);
      reg_rd(4'h2, 32'h0);
      dbg_set(seed);
      // Watchdog overflow with reset mode off is ignored; divide-by-4 tap keeps pulsing
      kick_once();
      n = 0;
      repeat (8) begin
         @(negedge clk_in);
         n += int'(tick[2] === 1'b1);
      end
      chk_pin(32'({n[3:0], cpu_rst_n}), 32'h5);
      reg_wr(IRS_CTRL_OFS, {25'h0, div_sel, 4'h1});
      kick_once();
      wait_cpu(1'b0, 6, n);
      chk_pin(32'(clk_ctl), 32'h0);
      chk_pin(32'({wclr, wrun, ram_blk, per_rst_n, div}), 32'h53);
      n = 1;
      while (wclr === 1'b1 && n < 100) begin
         @(negedge clk_in);
         n++;
      end
      chk_pin(32'(n >= WRST - 1 && n <= WRST + 1), 32'h1);
      chk_pin(32'({clk_ctl, wrun}), 32'h19);
      reg_rd(IRS_STATUS_OFS, 32'h20);
      wait_cpu(1'b1, 400, n);
      reg_rd(IRS_FLAGS_OFS, 32'h10);
      reg_rd(IRS_DEBUG_OFS, {24'h0, dbg_val});
      chk_pin(32'(dbg), 32'(dbg_val));
      chk_pin(32'(div), 32'h3);
      reg_wr(IRS_FLAGS_OFS, 32'h0);
      reg_rd(IRS_FLAGS_OFS, 32'h0);
      // Detect with the detector disabled: neither reset nor interrupt
      reg_wr(IRS_CTRL_OFS, {25'h0, div_sel, 4'h5});
      low_sup <= 1'b1;
      n = 0;
      repeat (8) begin
         @(negedge clk_in);
         n += int'(irq === 1'b1);
      end
      chk_pin(32'({n[3:0], cpu_rst_n}), 32'h1);
      low_sup <= 1'b0;
      // Low-voltage reset lasts as long as the detect level
      reg_wr(IRS_CTRL_OFS, {25'h0, div_sel, 4'h7});
      low_sup <= 1'b1;
      wait_cpu(1'b0, 8, n);
      repeat (20) @(negedge clk_in);
      chk_pin(32'({cpu_rst_n, wclr, clk_ctl}), 32'h10);
      reg_rd(IRS_STATUS_OFS, 32'h10);
      low_sup <= 1'b0;
      wait_cpu(1'b1, 400, n);
      reg_rd(IRS_FLAGS_OFS, 32'h1);
      // Select clear: interrupt instead of reset
      reg_wr(IRS_CTRL_OFS, {25'h0, div_sel, 4'h3});
      low_sup <= 1'b1;
      n = 0;
      repeat (12) begin
         @(negedge clk_in);
         n += int'(irq === 1'b1);
      end
      chk_pin(32'({n[3:0], cpu_rst_n}), 32'h3);
      low_sup <= 1'b0;
      // Flag clear in the same edge as a watchdog set: set wins
      @(posedge clk_in);
      kick  <= 1'b1;
      @(posedge clk_in);
      kick  <= 1'b0;
      addr  <= IRS_FLAGS_OFS;
      wdata <= 32'h1;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
      wait_cpu(1'b0, 6, n);
      wait_cpu(1'b1, 400, n);
      reg_rd(IRS_FLAGS_OFS, 32'h11);
      // Main clock never settles: watchdog overflow starts the CPU on the internal clock
      auto_en  <= 1'b1;
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      wait_cpu(1'b1, 400, n);
      chk_pin(32'({n < STAB, clk_st}), 32'h3);
      chk_pin(32'(dbg), 32'(IRS_DEBUG_INIT));
      reg_rd(IRS_STATUS_OFS, 32'h31);
      reg_rd(IRS_FLAGS_OFS, 32'h0);
      reg_rd(IRS_DEBUG_OFS, 32'h1);
      repeat (4) @(posedge clk_in);
      test_done();
   end

   // Random debug value and a divider other than the reset one
   task automatic dbg_set(input logic [31:0] s);
      dbg_val = s[7:0];
      div_sel = (s[10:8] == 3'h3) ? 3'h5 : s[10:8];
      reg_wr(IRS_DEBUG_OFS, {24'h0, dbg_val});
      reg_wr(IRS_CTRL_OFS, {25'h0, div_sel, 4'h0});
      reg_rd(IRS_DEBUG_OFS, {24'h0, dbg_val});
      @(negedge clk_in);
      chk_pin(32'(div), 32'(div_sel));
      chk_pin(32'(dbg), 32'(dbg_val));
   endtask
endmodule

`default_nettype wire
